// File: rtl/gp_timer_pkg.sv
// Constants for the general timer with event capture
// Operation
// - Capture count on selected event when enabled
// - Four-bit select picks source; 0101 reserved
// - Reload on timeout, or on clear write
// - Two-bit field selects one of four clocks
// - Disable stops timer and zeroes counter value
// - Start from 0 up, 0xffff down
// - Mode bit: free-running or periodic, periodic default
// - Direction bit: down at 0, up at 1
// - Prescaler divides by 1, 16, 256, 32768
// - Divide-by-one becomes four on fast clocks
// - Clear bits drop capture and timeout flags
// - Interrupt clear register always reads zero
// - Capture value held until capture flag cleared
// - Status bit 7 busy while clear syncs
// - Status bit 6 busy while control syncs
// - Status bit 1 shows capture pending
// - Status bit 0 set on timeout
package gp_timer_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] ADDR_VALUE   = 32'h40000404;
    localparam logic [31:0] ADDR_CONTROL = 32'h40000408;
    localparam logic [31:0] ADDR_CLEAR   = 32'h4000040c;
    localparam logic [31:0] ADDR_CAPTURE = 32'h40000410;
    localparam logic [31:0] ADDR_STATUS  = 32'h4000041c;
    localparam logic [31:0] ADDR_INT_EN  = 32'h40000420;
    // ----------------------------------------------------------------
    // Control fields and reset values
    // ----------------------------------------------------------------
    localparam int          CTL_CAPEN    = 12;
    localparam int          CTL_EVT_HI   = 11;
    localparam int          CTL_EVT_LO   = 8;
    localparam int          CTL_RELOAD   = 7;
    localparam int          CTL_CLK_HI   = 6;
    localparam int          CTL_CLK_LO   = 5;
    localparam int          CTL_EN       = 4;
    localparam int          CTL_MODE     = 3;
    localparam int          CTL_UP       = 2;
    localparam int          CTL_PRE_HI   = 1;
    localparam logic [15:0] CTL_RESET    = 16'h000a;
    localparam logic [15:0] CTL_MASK     = 16'h1fff;
    localparam logic [3:0]  EVT_RESERVED = 4'h5;
    localparam logic [1:0]  CLK_UNDIV    = 2'h0;
    localparam logic [1:0]  CLK_PERIPH   = 2'h1;
    localparam logic [1:0]  CLK_LOW_OSC  = 2'h2;
    localparam logic [1:0]  PRE_DIV1     = 2'h0;
    localparam logic [1:0]  PRE_DIV16    = 2'h1;
    localparam logic [1:0]  PRE_DIV256   = 2'h2;
    // ----------------------------------------------------------------
    // Status and clear bits, counter limits, sync length, responses
    // ----------------------------------------------------------------
    localparam int          ST_TIMEOUT   = 0;
    localparam int          ST_CAPTURE   = 1;
    localparam int          ST_CTRL_BUSY = 6;
    localparam int          ST_CLR_BUSY  = 7;
    localparam logic [15:0] COUNT_ZERO   = 16'h0000;
    localparam logic [15:0] COUNT_FULL   = 16'hffff;
    localparam logic [1:0]  SYNC_CYCLES  = 2'h2;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : gp_timer_pkg

// File: rtl/general_timer_with_capture.sv
// General 16-bit timer with event capture and AXI4-Lite registers
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module general_timer_with_capture #(
    parameter logic [15:0] DIV_FAST  = 16'h0004,
    parameter logic [15:0] DIV_16    = 16'h0010,
    parameter logic [15:0] DIV_256   = 16'h0100,
    parameter logic [15:0] DIV_32768 = 16'h8000
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output      logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output      logic        arready,
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready,
    input  wire logic        periphTick,
    input  wire logic        lfOscTick,
    input  wire logic        lfCrystalTick,
    input  wire logic [15:0] eventIn,
    input  wire logic [15:0] loadValue,
    output      logic        irq
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [15:0] timerControl;
    logic [15:0] activeControl;
    logic [15:0] counterValue;
    logic [15:0] captureValue;
    logic        timeoutFlag;
    logic        captureFlag;
    logic [1:0]  intEnable;
    logic [1:0]  ctrlSyncCnt;
    logic [1:0]  clrSyncCnt;
    logic [1:0]  pendingClear;
    logic        enablePrev;
    logic [14:0] prescaleCnt;
    logic        awHeld;
    logic        wHeld;
    logic [31:0] awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0]  wStrbHeld;

    logic        controlSyncBusy;
    logic        clearSyncBusy;
    logic        writeFire;
    logic [31:0] writeAddr;
    logic [31:0] writeData;
    logic        writeControl;
    logic        writeClear;
    logic        writeIntEn;
    logic        clearApply;
    logic        timerOn;
    logic        countUp;
    logic        periodic;
    logic        reloadOnClear;
    logic        sourceTick;
    logic        countTick;
    logic [15:0] divisor;
    logic [3:0]  eventSelect;
    logic        selectedEvent;
    logic        timeoutHit;
    logic [15:0] statusWord;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic mapped(input logic [31:0] addr);
        if (addr == gp_timer_pkg::ADDR_VALUE) begin
            mapped = 1'b1;
        end else if (addr == gp_timer_pkg::ADDR_CONTROL) begin
            mapped = 1'b1;
        end else if (addr == gp_timer_pkg::ADDR_CLEAR) begin
            mapped = 1'b1;
        end else if (addr == gp_timer_pkg::ADDR_CAPTURE) begin
            mapped = 1'b1;
        end else if (addr == gp_timer_pkg::ADDR_STATUS) begin
            mapped = 1'b1;
        end else if (addr == gp_timer_pkg::ADDR_INT_EN) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    endfunction : mapped

    // ----------------------------------------------------------------
    // AXI4-Lite write channels
    // ----------------------------------------------------------------
    // Address and data are held separately so they may arrive in either order
    assign awready   = !awHeld && !bvalid;
    assign wready    = !wHeld && !bvalid;
    assign writeAddr = awHeld ? awAddrHeld : awaddr;
    assign writeData = wHeld ? wDataHeld : wdata;
    assign writeFire = (awHeld || (awvalid && awready)) && (wHeld || (wvalid && wready));
    // Only the low byte lanes carry register bits
    assign writeControl = writeFire && (writeAddr == gp_timer_pkg::ADDR_CONTROL);
    assign writeClear   = writeFire && (writeAddr == gp_timer_pkg::ADDR_CLEAR);
    assign writeIntEn   = writeFire && (writeAddr == gp_timer_pkg::ADDR_INT_EN);

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld     <= 1'b0;
            wHeld      <= 1'b0;
            awAddrHeld <= 32'h00000000;
            wDataHeld  <= 32'h00000000;
            wStrbHeld  <= 4'h0;
        end else if (writeFire) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awHeld     <= 1'b1;
                awAddrHeld <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld     <= 1'b1;
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= gp_timer_pkg::RESP_OKAY;
        end else if (writeFire) begin
            bvalid <= 1'b1;
            bresp  <= mapped(writeAddr) ? gp_timer_pkg::RESP_OKAY : gp_timer_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control register and its sync into the timer
    // ----------------------------------------------------------------
    // Reserved bits are dropped on store rather than trusted to be zero
    always_ff @(posedge clk) begin
        if (rst) begin
            timerControl <= gp_timer_pkg::CTL_RESET;
        end else if (writeControl) begin
            timerControl <= writeData[15:0] & gp_timer_pkg::CTL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlSyncCnt   <= 2'h0;
            activeControl <= gp_timer_pkg::CTL_RESET;
        end else if (writeControl) begin
            ctrlSyncCnt <= gp_timer_pkg::SYNC_CYCLES;
        end else if (ctrlSyncCnt != 2'h0) begin
            ctrlSyncCnt <= ctrlSyncCnt - 2'h1;
            if (ctrlSyncCnt == 2'h1) begin
                activeControl <= timerControl;
            end
        end
    end
    assign controlSyncBusy = (ctrlSyncCnt != 2'h0);

    always_ff @(posedge clk) begin
        if (rst) begin
            clrSyncCnt   <= 2'h0;
            pendingClear <= 2'h0;
        end else if (writeClear) begin
            clrSyncCnt   <= gp_timer_pkg::SYNC_CYCLES;
            pendingClear <= writeData[1:0];
        end else if (clrSyncCnt != 2'h0) begin
            clrSyncCnt <= clrSyncCnt - 2'h1;
        end
    end
    assign clearSyncBusy = (clrSyncCnt != 2'h0);
    assign clearApply    = (clrSyncCnt == 2'h1) && !writeClear;

    always_ff @(posedge clk) begin
        if (rst) begin
            intEnable <= 2'h0;
        end else if (writeIntEn) begin
            intEnable <= writeData[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Clock source and prescaler
    // ----------------------------------------------------------------
    assign timerOn       = activeControl[gp_timer_pkg::CTL_EN];
    assign countUp       = activeControl[gp_timer_pkg::CTL_UP];
    assign periodic      = activeControl[gp_timer_pkg::CTL_MODE];
    assign reloadOnClear = activeControl[gp_timer_pkg::CTL_RELOAD];
    assign eventSelect   = activeControl[gp_timer_pkg::CTL_EVT_HI:gp_timer_pkg::CTL_EVT_LO];

    always_comb begin
        // The system clock itself ticks every cycle
        case (activeControl[gp_timer_pkg::CTL_CLK_HI:gp_timer_pkg::CTL_CLK_LO])
            gp_timer_pkg::CLK_UNDIV:  sourceTick = 1'b1;
            gp_timer_pkg::CLK_PERIPH: sourceTick = periphTick;
            gp_timer_pkg::CLK_LOW_OSC: sourceTick = lfOscTick;
            default:                  sourceTick = lfCrystalTick;
        endcase
    end

    always_comb begin
        case (activeControl[gp_timer_pkg::CTL_PRE_HI:0])
            // Fast clocks cannot be counted undivided, so divide by one runs as four
            gp_timer_pkg::PRE_DIV1: begin
                if (activeControl[gp_timer_pkg::CTL_CLK_HI]) begin
                    divisor = 16'h0001;
                end else begin
                    divisor = DIV_FAST;
                end
            end
            gp_timer_pkg::PRE_DIV16:  divisor = DIV_16;
            gp_timer_pkg::PRE_DIV256: divisor = DIV_256;
            default:                  divisor = DIV_32768;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || !timerOn) begin
            prescaleCnt <= 15'h0000;
        end else if (sourceTick) begin
            if ({1'b0, prescaleCnt} >= divisor - 16'h0001) begin
                prescaleCnt <= 15'h0000;
            end else begin
                prescaleCnt <= prescaleCnt + 15'h0001;
            end
        end
    end
    assign countTick = timerOn && enablePrev && sourceTick
                       && ({1'b0, prescaleCnt} >= divisor - 16'h0001);

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    assign timeoutHit = countTick && (countUp ? (counterValue == gp_timer_pkg::COUNT_FULL)
                                              : (counterValue == gp_timer_pkg::COUNT_ZERO));

    always_ff @(posedge clk) begin
        if (rst) begin
            enablePrev <= 1'b0;
        end else begin
            enablePrev <= timerOn;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !timerOn) begin
            counterValue <= gp_timer_pkg::COUNT_ZERO;
        end else if (!enablePrev) begin
            counterValue <= countUp ? gp_timer_pkg::COUNT_ZERO
                                    : gp_timer_pkg::COUNT_FULL;
        end else if (periodic && reloadOnClear && clearApply) begin
            counterValue <= loadValue;
        end else if (timeoutHit && periodic && !reloadOnClear) begin
            counterValue <= loadValue;
        end else if (countTick) begin
            // Free-running simply wraps through the full range
            counterValue <= countUp ? counterValue + 16'h0001
                                    : counterValue - 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Capture and flags
    // ----------------------------------------------------------------
    // Reserved select code is treated as no source at all
    assign selectedEvent = (eventSelect != gp_timer_pkg::EVT_RESERVED)
                           && eventIn[eventSelect];

    always_ff @(posedge clk) begin
        if (rst) begin
            captureValue <= gp_timer_pkg::COUNT_ZERO;
        end else if (selectedEvent && activeControl[gp_timer_pkg::CTL_CAPEN] && (!captureFlag
                     || (clearApply && pendingClear[gp_timer_pkg::ST_CAPTURE]))) begin
            captureValue <= counterValue;
        end
    end

    // Set wins over a clear landing in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            captureFlag <= 1'b0;
        end else if (selectedEvent && activeControl[gp_timer_pkg::CTL_CAPEN]) begin
            captureFlag <= 1'b1;
        end else if (clearApply && pendingClear[gp_timer_pkg::ST_CAPTURE]) begin
            captureFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timeoutFlag <= 1'b0;
        end else if (timeoutHit) begin
            timeoutFlag <= 1'b1;
        end else if (clearApply && pendingClear[gp_timer_pkg::ST_TIMEOUT]) begin
            timeoutFlag <= 1'b0;
        end
    end

    assign irq = (timeoutFlag && intEnable[gp_timer_pkg::ST_TIMEOUT])
                 || (captureFlag && intEnable[gp_timer_pkg::ST_CAPTURE]);

    always_comb begin
        statusWord = 16'h0000;
        statusWord[gp_timer_pkg::ST_TIMEOUT]   = timeoutFlag;
        statusWord[gp_timer_pkg::ST_CAPTURE]   = captureFlag;
        statusWord[gp_timer_pkg::ST_CTRL_BUSY] = controlSyncBusy;
        statusWord[gp_timer_pkg::ST_CLR_BUSY]  = clearSyncBusy;
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    assign arready = !rvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= gp_timer_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= gp_timer_pkg::RESP_OKAY;
            if (araddr == gp_timer_pkg::ADDR_VALUE) begin
                rdata <= {16'h0000, counterValue};
            end else if (araddr == gp_timer_pkg::ADDR_CONTROL) begin
                rdata <= {16'h0000, timerControl};
            end else if (araddr == gp_timer_pkg::ADDR_CLEAR) begin
                rdata <= 32'h00000000;
            end else if (araddr == gp_timer_pkg::ADDR_CAPTURE) begin
                rdata <= {16'h0000, captureValue};
            end else if (araddr == gp_timer_pkg::ADDR_STATUS) begin
                rdata <= {16'h0000, statusWord};
            end else if (araddr == gp_timer_pkg::ADDR_INT_EN) begin
                rdata <= {30'h00000000, intEnable};
            end else begin
                rdata <= 32'h00000000;
                rresp <= gp_timer_pkg::RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_capture_latch: assert property (@(posedge clk) disable iff (rst)
        (selectedEvent && activeControl[gp_timer_pkg::CTL_CAPEN] && !captureFlag)
        |=> (captureValue == $past(counterValue)) && captureFlag)
        else $error("capture did not latch counter");

    a_capture_gate: assert property (@(posedge clk) disable iff (rst)
        (!activeControl[gp_timer_pkg::CTL_CAPEN] && !captureFlag) |=> !captureFlag)
        else $error("capture flag set while capture disabled");

    a_capture_hold: assert property (@(posedge clk) disable iff (rst)
        (captureFlag && !clearApply) |=> $stable(captureValue))
        else $error("capture value overwritten while pending");

    a_reserved_event: assert property (@(posedge clk) disable iff (rst)
        (eventSelect == gp_timer_pkg::EVT_RESERVED) |-> !selectedEvent)
        else $error("reserved event code produced an event");

    a_clear_reads_zero: assert property (@(posedge clk) disable iff (rst)
        (arvalid && arready && araddr == gp_timer_pkg::ADDR_CLEAR) |=> (rdata == 32'h00000000))
        else $error("clear register read back nonzero");

    a_disable_zero: assert property (@(posedge clk) disable iff (rst)
        !timerOn |=> (counterValue == gp_timer_pkg::COUNT_ZERO))
        else $error("counter not reset while disabled");

    a_start_value: assert property (@(posedge clk) disable iff (rst)
        (timerOn && !enablePrev) |=> (counterValue == ($past(countUp) ?
            gp_timer_pkg::COUNT_ZERO : gp_timer_pkg::COUNT_FULL)))
        else $error("counter started from wrong value");

    a_con_sync: assert property (@(posedge clk) disable iff (rst)
        (writeControl && !controlSyncBusy) |=> controlSyncBusy [*2] ##1 !controlSyncBusy)
        else $error("control sync busy length wrong");

    a_clr_sync: assert property (@(posedge clk) disable iff (rst)
        (writeClear && !clearSyncBusy) |=> clearSyncBusy [*2] ##1 !clearSyncBusy)
        else $error("clear sync busy length wrong");

    a_timeout_flag: assert property (@(posedge clk) disable iff (rst)
        timeoutHit |=> timeoutFlag)
        else $error("timeout did not set status");

    a_periodic_reload: assert property (@(posedge clk) disable iff (rst)
        (timeoutHit && periodic && !reloadOnClear && enablePrev && !clearApply)
        |=> (counterValue == $past(loadValue)))
        else $error("periodic reload missed");

endmodule : general_timer_with_capture

// File: bench/tb_general_timer_with_capture.sv
// Self-checking bench for the general timer with event capture
`timescale 1ns/100ps
module tb_general_timer_with_capture;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic        clk = 1'b0, rst = 1'b1, irq;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic        periphTick = 1'b0, lfOscTick = 1'b0, lfCrystalTick = 1'b0;
    logic        oscPulse = 1'b0, evtPulse = 1'b0;
    logic [15:0] eventIn = '0, loadValue = 16'hfff0, rnd = 16'h001d;
    int          n_errors = 0, checks_done = 0, cycles = 0, ticks;
    logic [31:0] addrs [6] = '{gp_timer_pkg::ADDR_VALUE, gp_timer_pkg::ADDR_CONTROL,
        gp_timer_pkg::ADDR_CLEAR, gp_timer_pkg::ADDR_CAPTURE, gp_timer_pkg::ADDR_STATUS,
        gp_timer_pkg::ADDR_INT_EN};
    logic [31:0] resets [6] = '{32'h0, 32'h0000000a, 32'h0, 32'h0, 32'h0, 32'h0};

    // Small prescaler divisors keep the run short
    general_timer_with_capture #(.DIV_FAST(16'h0002), .DIV_16(16'h0004), .DIV_256(16'h0008),
        .DIV_32768(16'h0010)) i_general_timer_with_capture (.clk(clk), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .periphTick(periphTick), .lfOscTick(lfOscTick),
        .lfCrystalTick(lfCrystalTick), .eventIn(eventIn), .loadValue(loadValue), .irq(irq));

    always #12.5 clk = ~clk;

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsrNext

    // ----------------------------------------------------------------
    // Random side inputs, tick and event pulses, hang guard
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        rnd           <= lfsrNext(rnd);
        periphTick    <= rnd[0];
        lfCrystalTick <= rnd[1];
        lfOscTick     <= oscPulse;
        eventIn       <= {rnd[15:1], evtPulse};
        cycles        <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // AXI4-Lite master; each task starts one edge after the last ended
    // ----------------------------------------------------------------
    task axiWrite(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        fork
            begin do @(posedge clk); while (awready !== 1'b1); awvalid <= 1'b0; end
            begin do @(posedge clk); while (wready !== 1'b1); wvalid <= 1'b0; end
        join
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
        repeat (4) @(posedge clk);
    endtask : axiWrite

    task axiRead(input logic [31:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
    endtask : axiRead

    // Ticks reach the design one cycle late through the stimulus block
    task pulse(input int n, input bit evt);
        repeat (n) begin
            if (evt) evtPulse <= 1'b1;
            else oscPulse <= 1'b1;
            @(posedge clk);
            evtPulse <= 1'b0;
            oscPulse <= 1'b0;
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask : pulse

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            axiRead(addrs[i]);
            check(rd, resets[i]);
        end
        axiRead(32'h40000430);
        check({rd[31:2], resp}, {30'h0, gp_timer_pkg::RESP_SLVERR});
        axiWrite(32'h40000430, 32'h1);
        check(resp, gp_timer_pkg::RESP_SLVERR);
        // Up, free-run, oscillator source, divide by one, capture on code 0
        axiWrite(gp_timer_pkg::ADDR_CONTROL, 32'h00001054);
        axiRead(gp_timer_pkg::ADDR_STATUS);
        check(rd[6], 1'b0);
        ticks = rnd[3:0] + 1;
        pulse(ticks, 1'b0);
        axiRead(gp_timer_pkg::ADDR_VALUE);
        check(rd, ticks);
        pulse(1, 1'b1);
        axiRead(gp_timer_pkg::ADDR_CAPTURE);
        check(rd, ticks);
        axiRead(gp_timer_pkg::ADDR_STATUS);
        check(rd[1], 1'b1);
        pulse(2, 1'b0);
        pulse(1, 1'b1);
        axiRead(gp_timer_pkg::ADDR_CAPTURE);
        check(rd, ticks);
        axiWrite(gp_timer_pkg::ADDR_CLEAR, 32'h2);
        axiRead(gp_timer_pkg::ADDR_STATUS);
        check(rd[7:0], 8'h00);
        axiRead(gp_timer_pkg::ADDR_CLEAR);
        check(rd, 32'h0);
        axiWrite(gp_timer_pkg::ADDR_CONTROL, 32'h00001044);
        axiRead(gp_timer_pkg::ADDR_VALUE);
        check(rd, 32'h0);
        axiWrite(gp_timer_pkg::ADDR_CONTROL, 32'h00000050);
        axiRead(gp_timer_pkg::ADDR_VALUE);
        check(rd, 32'hffff);
        pulse(1, 1'b0);
        axiRead(gp_timer_pkg::ADDR_VALUE);
        check(rd, 32'hfffe);
        // Periodic up on the fast clock, reload on clear writes
        axiWrite(gp_timer_pkg::ADDR_INT_EN, 32'h3);
        axiWrite(gp_timer_pkg::ADDR_CONTROL, 32'h0000009c);
        axiWrite(gp_timer_pkg::ADDR_CLEAR, 32'h1);
        axiRead(gp_timer_pkg::ADDR_VALUE);
        // Four fast edges pass between reload and read: two ticks at divide-by-two
        check(rd, loadValue + 32'h2);
        // Same mode but reload on timeout, so the count stays near the load value
        axiWrite(gp_timer_pkg::ADDR_CONTROL, 32'h0000001c);
        repeat (60) @(posedge clk);
        axiRead(gp_timer_pkg::ADDR_STATUS);
        check(rd[0], 1'b1);
        @(negedge clk) check(irq, 1'b1);
        axiRead(gp_timer_pkg::ADDR_VALUE);
        check(rd[15:4], 12'hfff);
        axiWrite(gp_timer_pkg::ADDR_INT_EN, 32'h2);
        @(negedge clk) check(irq, 1'b0);
        axiWrite(gp_timer_pkg::ADDR_INT_EN, 32'h1);
        axiWrite(gp_timer_pkg::ADDR_CONTROL, 32'h0);
        axiWrite(gp_timer_pkg::ADDR_CLEAR, 32'h1);
        axiRead(gp_timer_pkg::ADDR_STATUS);
        check(rd[0], 1'b0);
        @(negedge clk) check(irq, 1'b0);
        // Up, free-run, oscillator source, divide by sixteen (four in this bench)
        axiWrite(gp_timer_pkg::ADDR_CONTROL, 32'h00000055);
        pulse(8, 1'b0);
        axiRead(gp_timer_pkg::ADDR_VALUE);
        check(rd, 32'h2);
        results();
    end
endmodule : tb_general_timer_with_capture
